// ===== include/smt_pkg.sv
// smt_pkg: constants and types for the temperature register port
// assumes a 25 MHz system clock and a conversion engine outside the block
package smt_pkg;
    // register map, byte pointer values
    localparam logic [7:0] SMT_ADDR_LOCAL  = 8'h07;
    localparam logic [7:0] SMT_ADDR_REM1   = 8'h01;
    localparam logic [7:0] SMT_ADDR_REM6   = 8'h06;
    localparam logic [7:0] SMT_ADDR_EXT    = 8'h10;
    localparam logic [7:0] SMT_ADDR_CFG    = 8'h41;
    localparam logic [7:0] SMT_PTR_RESET   = 8'h00;
    localparam logic [7:0] SMT_CFG_RESET   = 8'h00;
    localparam int         SMT_CFG_TO_DIS  = 5;
    // result codes
    localparam logic [7:0] SMT_TEMP_MAX    = 8'h7f;
    localparam logic [7:0] SMT_TEMP_ZERO   = 8'h00;
    localparam logic [7:0] SMT_TEMP_FAULT  = 8'hff;
    localparam logic signed [11:0] SMT_MAX_C8 = 12'sh3f8;
    localparam int         SMT_FRAC_BITS   = 3;
    localparam int         SMT_NUM_CHAN    = 7;
    // timing
    localparam int         SMT_CLK_KHZ     = 25000;
    localparam int         SMT_HOLD_TO_US  = 37000;
    localparam int         SMT_HOLD_CYC    = SMT_HOLD_TO_US * SMT_CLK_KHZ / 1000;

    // one finished conversion, temp in 1/8 degree steps, signed
    typedef struct packed {
        logic              valid;
        logic [2:0]        chan;
        logic signed [11:0] temp;
        logic              open_f;
        logic              short_f;
    } smt_conv_type;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
        ST_WDATA, ST_ACK_DATA, ST_TX, ST_TX_ACK
    } smt_state_type;
endpackage : smt_pkg

// ===== hw/smt_port.sv
// smt_port: bus slave register port of a multichannel temperature monitor
// assumes clock/data pins are open drain and resolved outside this module
`timescale 1ns/1ns
module smt_port
    import smt_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR  = 7'h4c,
    parameter int         HOLD_CYCLES = SMT_HOLD_CYC
) (
    // clock and reset
    input  wire logic         I_CLK_SYS,
    input  wire logic         I_SYS_RST,
    // bus pins
    input  wire logic         I_SCL,
    input  wire logic         I_SDA,
    output logic              O_SDA_O,
    output logic              O_SDA_OE,
    // conversion results
    input  wire smt_conv_type I_CONV,
    // status
    output logic              O_HOLD
);
    initial begin
        if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << 20))
            $error("HOLD_CYCLES out of range");
    end

    logic [2:0]    scl_sync_reg;
    logic [2:0]    sda_sync_reg;
    logic          scl_reg;
    logic          sda_reg;
    smt_state_type state_reg;
    logic [3:0]    cnt_reg;
    logic [7:0]    sh_reg;
    logic          rw_reg;
    logic [7:0]    ptr_reg;
    logic [7:0]    cfg_reg;
    logic [7:0]    temp_reg [SMT_NUM_CHAN];
    logic [7:0]    ext_reg;
    logic          hold_reg;
    logic [19:0]   hold_cnt_reg;
    logic          oe_reg;
    logic [7:0]    rd_val;

    // one value register per channel; local channel sits at index 0
    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input logic [7:0] t [SMT_NUM_CHAN],
                                            input logic [7:0] e,
                                            input logic [7:0] c);
        logic [7:0] r;
        r = 8'h00;
        if (a == SMT_ADDR_LOCAL)
            r = t[0];
        else if (a >= SMT_ADDR_REM1 && a <= SMT_ADDR_REM6)
            r = t[a[2:0]];
        else if (a == SMT_ADDR_EXT)
            r = e;
        else if (a == SMT_ADDR_CFG)
            r = c;
        return r;
    endfunction : read_reg

    // high byte and extended byte of one result
    function automatic logic [15:0] fmt(input smt_conv_type c);
        logic [15:0] r;
        r = {SMT_TEMP_ZERO, 8'h00};
        if (c.open_f || c.short_f)
            r = {SMT_TEMP_FAULT, 8'h00};
        else if (c.temp >= SMT_MAX_C8)
            r = {SMT_TEMP_MAX, 8'h00};
        else if (c.temp > 12'sh000)
            r = {1'b0, c.temp[9:3], c.temp[2:0], 5'h00};
        return r;
    endfunction : fmt

    // pin filter: level moves only when second and third stage agree
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg      <= 1'b1;
            sda_reg      <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], I_SCL};
            sda_sync_reg <= {sda_sync_reg[1:0], I_SDA};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_reg <= sda_sync_reg[2];
        end
    end

    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_hit;
    logic rd_load;
    logic wr_now;
    assign scl_new   = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2]
                                                            : scl_reg;
    assign sda_new   = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2]
                                                            : sda_reg;
    assign scl_rise  = scl_new & ~scl_reg;
    assign scl_fall  = ~scl_new & scl_reg;
    assign start_det = scl_reg & scl_new & sda_reg & ~sda_new;
    assign stop_det  = scl_reg & scl_new & ~sda_reg & sda_new;
    assign addr_hit  = (sh_reg[7:1] == SLAVE_ADDR);
    // data loaded for the host: after address ack of a read, or after its ack
    assign rd_load   = scl_fall && rw_reg
                       && (state_reg == ST_ACK_ADDR
                           || (state_reg == ST_TX_ACK && !sda_reg));
    assign wr_now    = scl_fall && state_reg == ST_WDATA && cnt_reg == 4'h8;
    // byte the pointer selects; one decode shared by both load points
    assign rd_val    = read_reg(ptr_reg, temp_reg, ext_reg, cfg_reg);

    // protocol engine; start or stop wins over any phase
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            sh_reg    <= 8'h00;
            rw_reg    <= 1'b0;
            oe_reg    <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_ADDR;
            cnt_reg   <= 4'h0;
            oe_reg    <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && cnt_reg != 4'h8) begin
                        sh_reg  <= {sh_reg[6:0], sda_reg};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_reg <= 4'h0;
                        oe_reg  <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_reg    <= sh_reg[0];
                            state_reg <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
                            oe_reg    <= addr_hit;
                        end else if (state_reg == ST_CMD)
                            state_reg <= ST_ACK_CMD;
                        else
                            state_reg <= ST_ACK_DATA;
                    end
                end
                ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_DATA: begin
                    if (scl_fall) begin
                        oe_reg <= 1'b0;
                        if (state_reg == ST_ACK_ADDR && rw_reg) begin
                            state_reg <= ST_TX;
                            sh_reg    <= rd_val;
                            oe_reg    <= ~rd_val[7];
                            cnt_reg   <= 4'h1;
                        end else if (state_reg == ST_ACK_ADDR)
                            state_reg <= ST_CMD;
                        else
                            state_reg <= ST_WDATA;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            oe_reg    <= 1'b0;
                            state_reg <= ST_TX_ACK;
                        end else begin
                            oe_reg  <= ~sh_reg[6];
                            sh_reg  <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // host ack asks for the same register again
                    if (scl_fall) begin
                        if (sda_reg)
                            state_reg <= ST_IDLE;
                        else begin
                            state_reg <= ST_TX;
                            sh_reg    <= rd_val;
                            oe_reg    <= ~rd_val[7];
                            cnt_reg   <= 4'h1;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // pointer and writable targets
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            ptr_reg <= SMT_PTR_RESET;
            cfg_reg <= SMT_CFG_RESET;
        end else begin
            if (scl_fall && state_reg == ST_CMD && cnt_reg == 4'h8)
                ptr_reg <= sh_reg;
            if (wr_now && ptr_reg == SMT_ADDR_CFG)
                cfg_reg <= sh_reg;
        end
    end

    // result store; channel one high and low bytes move together
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            for (int i = 0; i < SMT_NUM_CHAN; i++)
                temp_reg[i] <= SMT_TEMP_ZERO;
            ext_reg <= 8'h00;
        end else if (I_CONV.valid && I_CONV.chan < 3'(SMT_NUM_CHAN)) begin
            if (I_CONV.chan != 3'h1)
                temp_reg[I_CONV.chan] <= fmt(I_CONV)[15:8];
            else if (!hold_reg) begin
                temp_reg[1] <= fmt(I_CONV)[15:8];
                ext_reg     <= fmt(I_CONV)[7:0];
            end
        end
    end

    // hold of channel one high byte, a new extended read restarts it
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            hold_reg     <= 1'b0;
            hold_cnt_reg <= 20'h00000;
        end else if (rd_load && ptr_reg == SMT_ADDR_EXT) begin
            hold_reg     <= 1'b1;
            hold_cnt_reg <= 20'h00000;
        end else if (hold_reg) begin
            hold_cnt_reg <= hold_cnt_reg + 20'h00001;
            if (rd_load && ptr_reg == SMT_ADDR_REM1)
                hold_reg <= 1'b0;
            else if (!cfg_reg[SMT_CFG_TO_DIS]
                     && hold_cnt_reg == 20'(HOLD_CYCLES - 1))
                hold_reg <= 1'b0;
        end
    end

    assign O_SDA_O  = 1'b0;
    assign O_SDA_OE = oe_reg;
    assign O_HOLD   = hold_reg;

    chk_ptr_reset: assert property (@(posedge I_CLK_SYS)
        I_SYS_RST |=> ptr_reg == SMT_PTR_RESET)
        else $error("pointer not cleared by reset");
    chk_send_only_ptr: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        state_reg == ST_ACK_CMD |=> $stable(cfg_reg))
        else $error("command phase altered a register");
    chk_write_store: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        wr_now && ptr_reg == SMT_ADDR_CFG |=> cfg_reg == $past(sh_reg))
        else $error("written byte not stored");
    chk_hold_start: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        rd_load && ptr_reg == SMT_ADDR_EXT |=> hold_reg ##0 O_HOLD)
        else $error("extended read did not start hold");
    chk_hold_freeze: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        hold_reg && I_CONV.valid && I_CONV.chan == 3'h1
        |=> $stable(temp_reg[1]) && $stable(ext_reg))
        else $error("held byte overwritten");
    chk_hold_timeout: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        hold_reg && !rd_load && !cfg_reg[SMT_CFG_TO_DIS]
        && hold_cnt_reg == 20'(HOLD_CYCLES - 1) |=> !hold_reg)
        else $error("hold not released at timeout");
    chk_sat_high: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        I_CONV.valid && I_CONV.chan == 3'h0 && !I_CONV.open_f
        && !I_CONV.short_f && I_CONV.temp >= SMT_MAX_C8
        |=> temp_reg[0] == SMT_TEMP_MAX)
        else $error("high byte not clamped");
    chk_fault_code: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        I_CONV.valid && I_CONV.open_f && I_CONV.chan == 3'h5
        |=> temp_reg[5] == SMT_TEMP_FAULT)
        else $error("fault code missing");
    chk_addr_miss: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        state_reg == ST_ADDR && scl_fall && cnt_reg == 4'h8 && !addr_hit
        && !start_det && !stop_det |=> state_reg == ST_IDLE && !O_SDA_OE)
        else $error("foreign address acknowledged");
    chk_read_data: assert property (@(posedge I_CLK_SYS)
        disable iff (I_SYS_RST)
        rd_load && !start_det && !stop_det
        |=> sh_reg == $past(rd_val))
        else $error("wrong register loaded for host");
endmodule : smt_port

// ===== sim/smt_host_model.sv
// smt_host_model: bus host master that drives the temperature register port
// assumes open-drain lines with pull-ups, resolved by the bench
`timescale 1ns/1ns
module smt_host_model #(
    parameter logic [6:0] ADDR = 7'h4c,
    parameter int         PH   = 10
) (
    // clock
    input  wire logic i_clk,
    // bus lines
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    logic acked;

    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
        acked     = 1'b0;
    end

    // phases of ten cycles keep clear of the eight-cycle minimum
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wt

    // data only moves while the clock line is low
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = ~b;
        wt(PH);
        o_scl = 1'b1;
        wt(PH / 2);
        r = i_sda;
        wt(PH / 2);
        o_scl = 1'b0;
    endtask : bit_io

    // msb first, ninth bit always released: reads end with a nack
    task automatic byte_io(input logic [7:0] d, input logic wr,
                           output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        if (wr) acked = acked & ~a;
    endtask : byte_io

    // also serves as repeated start when the clock line is low
    task automatic start(input logic [6:0] a, input logic rd);
        logic [7:0] r;
        o_sda_low = 1'b0;
        wt(PH);
        o_scl = 1'b1;
        wt(PH);
        o_sda_low = 1'b1;
        wt(PH);
        o_scl = 1'b0;
        byte_io({a, rd}, 1'b1, r);
    endtask : start

    task automatic stop;
        o_sda_low = 1'b1;
        wt(PH);
        o_scl = 1'b1;
        wt(PH);
        o_sda_low = 1'b0;
        wt(PH);
    endtask : stop

    // write byte, send byte or read byte, chosen by wd and rd
    task automatic command(input logic [7:0] c, input logic wd,
                           input logic [7:0] d, input logic rd,
                           output logic [7:0] q);
        logic [7:0] r;
        acked = 1'b1;
        start(ADDR, 1'b0);
        byte_io(c, 1'b1, r);
        if (wd) byte_io(d, 1'b1, r);
        if (rd) begin
            start(ADDR, 1'b1);
            byte_io(8'hff, 1'b0, q);
        end
        stop();
    endtask : command

    // single master here, so the shared pointer cannot move underneath
    task automatic recv(input logic [6:0] a, output logic [7:0] q);
        acked = 1'b1;
        start(a, 1'b1);
        byte_io(8'hff, 1'b0, q);
        stop();
    endtask : recv
endmodule : smt_host_model

// ===== sim/smt_port_test.sv
// smt_port_test: self-checking bench for the temperature register port
// assumes the host model owns the bus; the bench resolves open drain
`timescale 1ns/1ns
module smt_port_test;
    import smt_pkg::*;
    // short hold window so the timeout fits the run
    localparam int         HOLD  = 2000;
    localparam logic [6:0] SADDR = 7'h4c;
    logic         clk;
    logic         rst;
    logic         scl;
    logic         host_low;
    logic         sda;
    logic         sda_o;
    logic         sda_oe;
    logic         hold;
    smt_conv_type conv;
    logic [7:0]   q;
    int           fails;
    int           n_checks;
    int           cyc;
    logic [11:0]  tt [7] = '{12'h3f8, 12'd205, 12'd208, 12'd1040,
                             -12'sd40, 12'd0, 12'd0};
    logic [7:0]   ex [7] = '{8'h7f, 8'h19, 8'h1a, 8'h7f, 8'h00, 8'hff, 8'hff};

    assign sda = ~(host_low | (sda_oe & ~sda_o));

    smt_port #(.SLAVE_ADDR(SADDR), .HOLD_CYCLES(HOLD)) DUT (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_CONV(conv), .O_HOLD(hold));
    smt_host_model #(.ADDR(SADDR), .PH(10)) host (
        .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic end_sim;
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            end_sim();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic load(input logic [2:0] ch, input logic [11:0] t,
                        input logic op, input logic sh);
        conv = '{1'b1, ch, t, op, sh};
        @(negedge clk);
        conv.valid = 1'b0;
    endtask : load

    task automatic read_byte(input logic [7:0] c, output logic [7:0] d);
        host.command(c, 1'b0, 8'h00, 1'b1, d);
    endtask : read_byte

    task automatic write_byte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        host.command(c, 1'b1, d, 1'b0, r);
    endtask : write_byte

    initial begin
        rst = 1'b1;
        conv = '0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk1(hold, 1'b0);
        host.recv(SADDR, q);
        chk8(q, 8'h00);
        chk1(host.acked, 1'b1);
        for (int c = 0; c < 7; c++) begin
            load(3'(c), tt[c], c == 5, c == 6);
            read_byte(c == 0 ? SMT_ADDR_LOCAL : 8'(c), q);
            chk8(q, ex[c]);
        end
        read_byte(8'h02, q);
        host.recv(SADDR, q);
        chk8(q, 8'h1a);
        host.command(8'h03, 1'b0, 8'h00, 1'b0, q);
        host.recv(SADDR, q);
        chk8(q, 8'h7f);
        write_byte(SMT_ADDR_CFG, 8'h0c);
        host.recv(SADDR, q);
        chk8(q, 8'h0c);
        write_byte(SMT_ADDR_REM1, 8'h55);
        read_byte(SMT_ADDR_REM1, q);
        chk8(q, 8'h19);
        host.recv(SADDR ^ 7'h01, q);
        chk1(host.acked, 1'b0);
        chk8(q, 8'hff);
        read_byte(SMT_ADDR_EXT, q);
        chk8(q, 8'ha0);
        chk1(hold, 1'b1);
        load(3'd1, 12'd240, 1'b0, 1'b0);
        read_byte(SMT_ADDR_REM1, q);
        chk8(q, 8'h19);
        chk1(hold, 1'b0);
        load(3'd1, 12'd240, 1'b0, 1'b0);
        read_byte(SMT_ADDR_REM1, q);
        chk8(q, 8'h1e);
        read_byte(SMT_ADDR_EXT, q);
        chk8(q, 8'h00);
        repeat (HOLD / 2) @(negedge clk);
        chk1(hold, 1'b1);
        repeat (HOLD) @(negedge clk);
        chk1(hold, 1'b0);
        load(3'd1, 12'd248, 1'b0, 1'b0);
        read_byte(SMT_ADDR_REM1, q);
        chk8(q, 8'h1f);
        end_sim();
    end
endmodule : smt_port_test
